//--- smsl_pkg.sv
package smsl_pkg;

  // frame layout, counted in bits from the first preamble bit
  localparam int SMSL_PRE_BITS = 32;
  localparam int SMSL_FRAME_BITS = 64;
  localparam logic [5:0] SMSL_TA_IDX = 6'h2_e;
  localparam logic [5:0] SMSL_DATA_IDX = 6'h3_0;
  localparam logic [5:0] SMSL_LAST_IDX = 6'h3_f;
  localparam logic [1:0] SMSL_START = 2'h1;
  localparam logic [1:0] SMSL_OP_READ = 2'h2;
  localparam logic [1:0] SMSL_OP_WRITE = 2'h1;
  localparam logic [1:0] SMSL_TA_WRITE = 2'h2;
  localparam logic [31:0] SMSL_PREAMBLE = 32'hffff_ffff;

  // phy addresses that select ports 1 to 4
  localparam logic [4:0] SMSL_PORT_MIN = 5'h01;
  localparam logic [4:0] SMSL_PORT_MAX = 5'h04;

  // direct register numbers
  localparam logic [4:0] SMSL_REG_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] SMSL_REG_BASIC_STATUS = 5'h01;
  localparam logic [4:0] SMSL_REG_ID_HIGH = 5'h02;
  localparam logic [4:0] SMSL_REG_ID_LOW = 5'h03;
  localparam logic [4:0] SMSL_REG_AN_ADVERT = 5'h04;
  localparam logic [4:0] SMSL_REG_LP_ABILITY = 5'h05;
  localparam logic [4:0] SMSL_REG_AN_EXPANSION = 5'h06;
  localparam logic [4:0] SMSL_REG_AN_NEXT_PAGE = 5'h07;
  localparam logic [4:0] SMSL_REG_LP_NEXT_PAGE = 5'h08;
  localparam logic [4:0] SMSL_REG_EXT_SETUP = 5'h0d;
  localparam logic [4:0] SMSL_REG_EXT_DATA = 5'h0e;
  localparam logic [4:0] SMSL_REG_REMOTE_LOOP = 5'h11;
  localparam logic [4:0] SMSL_REG_PCS_STATUS = 5'h13;
  localparam logic [4:0] SMSL_REG_RX_ERR_COUNT = 5'h15;
  localparam logic [4:0] SMSL_REG_PORT_INT = 5'h1b;
  localparam logic [4:0] SMSL_REG_CROSSOVER = 5'h1c;
  localparam logic [4:0] SMSL_REG_PHY_CONTROL = 5'h1f;

  // byte space: port n register r at 0xn100 + 2r, high byte first
  localparam logic [5:0] SMSL_BYTE_REGION = 6'h04;
  localparam logic [1:0] SMSL_EXT_FUNC_ADDR = 2'h0;

  // clocks: management clock never above 5 MHz
  localparam longint SMSL_SYS_HZ = 250_000_000;
  localparam longint SMSL_MDC_MAX_HZ = 5_000_000;
  localparam int SMSL_MDC_HALF_CYC =
    int'((SMSL_SYS_HZ + 2 * SMSL_MDC_MAX_HZ - 1) / (2 * SMSL_MDC_MAX_HZ));

  // controller register map, byte addresses
  localparam logic [7:0] SMSL_HOST_CMD = 8'h00;
  localparam logic [7:0] SMSL_HOST_WDATA = 8'h04;
  localparam logic [7:0] SMSL_HOST_RDATA = 8'h08;
  localparam logic [7:0] SMSL_HOST_STATUS = 8'h0c;
  localparam logic [7:0] SMSL_HOST_INT_STAT = 8'h10;
  localparam logic [7:0] SMSL_HOST_INT_CLR = 8'h14;
  localparam logic [7:0] SMSL_HOST_INT_EN = 8'h18;
  localparam int SMSL_CMD_RA_LSB = 0;
  localparam int SMSL_CMD_PA_LSB = 5;
  localparam int SMSL_CMD_RD_BIT = 10;
  localparam int SMSL_INT_RD_DONE = 0;
  localparam int SMSL_INT_WR_DONE = 1;

  // register numbers that have storage behind them
  function automatic logic smsl_reg_used(input logic [4:0] r);
    unique case (r)
      5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0f, 5'h10, 5'h12, 5'h14,
      5'h16, 5'h17, 5'h18, 5'h19, 5'h1a, 5'h1d, 5'h1e: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction : smsl_reg_used

  // registers that a frame may change; status and id are read only
  function automatic logic smsl_reg_writable(input logic [4:0] r);
    unique case (r)
      SMSL_REG_BASIC_STATUS, SMSL_REG_ID_HIGH, SMSL_REG_ID_LOW,
      SMSL_REG_LP_ABILITY, SMSL_REG_AN_EXPANSION, SMSL_REG_LP_NEXT_PAGE,
      SMSL_REG_PCS_STATUS, SMSL_REG_RX_ERR_COUNT: return 1'b0;
      default: return smsl_reg_used(r);
    endcase
  endfunction : smsl_reg_writable

endpackage : smsl_pkg

//--- smsl_if.sv
`timescale 1ns/100ps
interface smsl_if;
  logic mdc;
  logic mdio_host_o;
  logic mdio_host_oe;
  logic mdio_dev_o;
  logic mdio_dev_oe;
  logic mdio_line;

  // open-drain wire with pull-up: low while any enabled driver is low
  assign mdio_line = ~((mdio_host_oe & ~mdio_host_o) |
                       (mdio_dev_oe & ~mdio_dev_o));

  modport host (output mdc, output mdio_host_o, output mdio_host_oe,
                input mdio_line);
  modport dev (input mdc, output mdio_dev_o, output mdio_dev_oe,
               input mdio_line);
endinterface : smsl_if

//--- smsl_device.sv
`timescale 1ns/100ps
module smsl_device
  import smsl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  smsl_if.dev link,
  input wire logic [15:0] hp_addr,
  input wire logic [7:0] hp_wdata,
  input wire logic hp_we,
  input wire logic hp_re,
  output logic [7:0] hp_rdata
);

  typedef enum logic [6:0] {
    SMSL_D_PRE = 7'h01,
    SMSL_D_START = 7'h02,
    SMSL_D_OP = 7'h04,
    SMSL_D_PA = 7'h08,
    SMSL_D_RA = 7'h10,
    SMSL_D_TA = 7'h20,
    SMSL_D_DATA = 7'h40
  } smsl_dstate_t;

  smsl_dstate_t state_r;
  logic mdc_s1_r, mdc_s2_r, mdc_s3_r;
  logic mdio_s1_r, mdio_s2_r;
  logic [5:0] ones_r;
  logic [3:0] cnt_r;
  logic [1:0] op_r;
  logic [4:0] pa_r;
  logic [4:0] ra_r;
  logic [15:0] sh_r;
  logic oe_r;
  logic o_r;
  logic [7:0] mem [0:255];
  logic [15:0] ext_addr_r [0:3];
  logic [15:0] ext_mem [0:63];
  logic [7:0] hp_rdata_r;

  logic rise;
  logic bit_in;
  logic sel;
  logic [1:0] pidx;
  logic [15:0] rd_word;
  logic [15:0] wr_word;
  logic wr_commit;
  logic [1:0] ext_func;
  logic [8:0] hp_idx;

  // byte host address to array index, or miss
  function automatic logic [8:0] byte_index(input logic [15:0] a);
    logic [3:0] n;
    n = a[15:12];
    if (n >= 4'h1 && n <= 4'h4 && a[11:6] == SMSL_BYTE_REGION &&
        smsl_reg_used(a[5:1])) begin
      return {1'b1, 2'(n - 4'h1), a[5:1], a[0]};
    end
    return 9'h000;
  endfunction : byte_index

  // the clock and line come from another party: two flops first
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mdc_s1_r <= 1'b0;
      mdc_s2_r <= 1'b0;
      mdc_s3_r <= 1'b0;
      mdio_s1_r <= 1'b1;
      mdio_s2_r <= 1'b1;
    end else begin
      mdc_s1_r <= link.mdc;
      mdc_s2_r <= mdc_s1_r;
      mdc_s3_r <= mdc_s2_r;
      mdio_s1_r <= link.mdio_line;
      mdio_s2_r <= mdio_s1_r;
    end
  end

  assign rise = mdc_s2_r & ~mdc_s3_r;
  assign bit_in = mdio_s2_r;
  // a frame is ours only for phy address 1..4 and a valid opcode
  assign sel = (pa_r >= SMSL_PORT_MIN) && (pa_r <= SMSL_PORT_MAX) &&
               (op_r == SMSL_OP_READ || op_r == SMSL_OP_WRITE);
  assign pidx = 2'(pa_r - SMSL_PORT_MIN);
  assign ext_func = mem[{pidx, SMSL_REG_EXT_SETUP, 1'b0}][7:6];
  assign wr_word = {sh_r[14:0], bit_in};
  // one decode of the byte address, shared by the write and read paths
  assign hp_idx = byte_index(hp_addr);
  assign wr_commit = rise && state_r == SMSL_D_DATA && cnt_r == 4'hf &&
                     op_r == SMSL_OP_WRITE && sel;

  // word seen by a read frame; data register goes through the pair
  always_comb begin
    rd_word = 16'h0000;
    if (smsl_reg_used(ra_r)) begin
      if (ra_r == SMSL_REG_EXT_DATA) begin
        rd_word = (ext_func == SMSL_EXT_FUNC_ADDR) ? ext_addr_r[pidx] :
                  ext_mem[{pidx, ext_addr_r[pidx][3:0]}];
      end else begin
        rd_word = {mem[{pidx, ra_r, 1'b0}], mem[{pidx, ra_r, 1'b1}]};
      end
    end
  end

  // frame decoder, stepped once per rising management clock edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= SMSL_D_PRE;
      ones_r <= 6'h00;
      cnt_r <= 4'h0;
      op_r <= 2'h0;
      pa_r <= 5'h00;
      ra_r <= 5'h00;
      sh_r <= 16'h0000;
      oe_r <= 1'b0;
      o_r <= 1'b1;
    end else if (rise) begin
      unique case (state_r)
        SMSL_D_PRE: begin
          if (bit_in) begin
            if (ones_r != 6'(SMSL_PRE_BITS)) ones_r <= ones_r + 6'h01;
          end else if (ones_r == 6'(SMSL_PRE_BITS)) begin
            state_r <= SMSL_D_START;
          end else begin
            ones_r <= 6'h00;
          end
        end
        SMSL_D_START: begin
          ones_r <= 6'h00;
          cnt_r <= 4'h0;
          state_r <= bit_in ? SMSL_D_OP : SMSL_D_PRE;
        end
        SMSL_D_OP: begin
          op_r <= {op_r[0], bit_in};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h1) begin
            cnt_r <= 4'h0;
            state_r <= SMSL_D_PA;
          end
        end
        SMSL_D_PA: begin
          pa_r <= {pa_r[3:0], bit_in};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h4) begin
            cnt_r <= 4'h0;
            state_r <= SMSL_D_RA;
          end
        end
        SMSL_D_RA: begin
          ra_r <= {ra_r[3:0], bit_in};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h4) begin
            cnt_r <= 4'h0;
            state_r <= SMSL_D_TA;
          end
        end
        SMSL_D_TA: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h0) begin
            // drive the zero of the second turnaround bit
            oe_r <= sel && op_r == SMSL_OP_READ;
            o_r <= 1'b0;
            sh_r <= rd_word;
          end else begin
            o_r <= sh_r[15];
            sh_r <= {sh_r[14:0], 1'b0};
            cnt_r <= 4'h0;
            state_r <= SMSL_D_DATA;
          end
        end
        SMSL_D_DATA: begin
          cnt_r <= cnt_r + 4'h1;
          if (op_r == SMSL_OP_READ) begin
            o_r <= sh_r[15];
            sh_r <= {sh_r[14:0], 1'b0};
          end else begin
            sh_r <= wr_word;
          end
          if (cnt_r == 4'hf) begin
            oe_r <= 1'b0;
            o_r <= 1'b1;
            cnt_r <= 4'h0;
            state_r <= SMSL_D_PRE;
          end
        end
        default: state_r <= SMSL_D_PRE;
      endcase
    end
  end

  // shared byte storage: frame writes win a same-cycle byte write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) mem[i] <= 8'h00;
    end else if (wr_commit && smsl_reg_writable(ra_r) &&
                 ra_r != SMSL_REG_EXT_DATA) begin
      mem[{pidx, ra_r, 1'b0}] <= wr_word[15:8];
      mem[{pidx, ra_r, 1'b1}] <= wr_word[7:0];
    end else if (hp_we && hp_idx[8]) begin
      mem[hp_idx[7:0]] <= hp_wdata;
    end
  end

  // extended space behind the setup/data pair
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) ext_addr_r[i] <= 16'h0000;
      for (int i = 0; i < 64; i++) ext_mem[i] <= 16'h0000;
    end else if (wr_commit && ra_r == SMSL_REG_EXT_DATA) begin
      if (ext_func == SMSL_EXT_FUNC_ADDR) begin
        ext_addr_r[pidx] <= wr_word;
      end else begin
        ext_mem[{pidx, ext_addr_r[pidx][3:0]}] <= wr_word;
      end
    end
  end

  // byte host read, answered one cycle later; misses read zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hp_rdata_r <= 8'h00;
    end else if (hp_re) begin
      hp_rdata_r <= hp_idx[8] ? mem[hp_idx[7:0]] : 8'h00;
    end
  end

  assign hp_rdata = hp_rdata_r;
  assign link.mdio_dev_oe = oe_r;
  assign link.mdio_dev_o = o_r;

endmodule : smsl_device

//--- smsl_host.sv
`timescale 1ns/100ps
module smsl_host
  import smsl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  smsl_if.host link,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq
);

  logic busy_r;
  logic mdc_r;
  logic [5:0] div_r;
  logic [5:0] idx_r;
  logic [63:0] tx_r;
  logic [15:0] rx_r;
  logic [15:0] rdat_r;
  logic [15:0] wdat_r;
  logic rd_op_r;
  logic [1:0] ist_r;
  logic [1:0] ien_r;
  logic [31:0] rdata_r;
  logic mdio_s1_r, mdio_s2_r;
  logic tick;
  logic go;
  logic done;
  logic [1:0] ev;

  assign tick = busy_r && div_r == 6'(SMSL_MDC_HALF_CYC - 1);
  assign go = wr && addr == SMSL_HOST_CMD && !busy_r; // busy drops it
  assign done = tick && mdc_r && idx_r == SMSL_LAST_IDX;
  assign ev = {done && !rd_op_r, done && rd_op_r};

  // returning line comes through two flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mdio_s1_r <= 1'b1;
      mdio_s2_r <= 1'b1;
    end else begin
      mdio_s1_r <= link.mdio_line;
      mdio_s2_r <= mdio_s1_r;
    end
  end

  // clock divider: half period rounded up keeps rate at or under the limit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_r <= 6'h00;
      mdc_r <= 1'b0;
    end else if (!busy_r || tick) begin
      div_r <= 6'h00;
      mdc_r <= busy_r && !mdc_r;
    end else begin
      div_r <= div_r + 6'h01;
    end
  end

  // frame shifter: bits change on the falling edge, read on the rising
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      idx_r <= 6'h00;
      tx_r <= 64'h0000_0000_0000_0000;
      rx_r <= 16'h0000;
      rdat_r <= 16'h0000;
      rd_op_r <= 1'b0;
    end else if (go) begin
      busy_r <= 1'b1;
      idx_r <= 6'h00;
      rd_op_r <= wdata[SMSL_CMD_RD_BIT];
      tx_r <= {SMSL_PREAMBLE, SMSL_START,
               wdata[SMSL_CMD_RD_BIT] ? SMSL_OP_READ : SMSL_OP_WRITE,
               wdata[SMSL_CMD_PA_LSB +: 5], wdata[SMSL_CMD_RA_LSB +: 5],
               SMSL_TA_WRITE, wdat_r};
    end else if (tick && !mdc_r) begin
      if (idx_r >= SMSL_DATA_IDX) rx_r <= {rx_r[14:0], mdio_s2_r};
    end else if (tick) begin
      if (done) begin
        busy_r <= 1'b0;
        if (rd_op_r) rdat_r <= rx_r;
      end else begin
        idx_r <= idx_r + 6'h01;
        tx_r <= {tx_r[62:0], 1'b1};
      end
    end
  end

  // open drain: pull low for a zero, release for a one and from a read's turnaround on
  assign link.mdc = mdc_r;
  assign link.mdio_host_o = 1'b0;
  assign link.mdio_host_oe = busy_r && !tx_r[63] &&
                             !(rd_op_r && idx_r >= SMSL_TA_IDX);

  // registers; an event in the clearing cycle stays set
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdat_r <= 16'h0000;
      ien_r <= 2'h0;
      ist_r <= 2'h0;
    end else begin
      if (wr && addr == SMSL_HOST_WDATA) wdat_r <= wdata[15:0];
      if (wr && addr == SMSL_HOST_INT_EN) ien_r <= wdata[1:0];
      if (wr && addr == SMSL_HOST_INT_CLR) begin
        ist_r <= (ist_r & ~wdata[1:0]) | ev;
      end else begin
        ist_r <= ist_r | ev;
      end
    end
  end

  // read answer one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd) begin
      unique case (addr)
        SMSL_HOST_WDATA: rdata_r <= {16'h0000, wdat_r};
        SMSL_HOST_RDATA: rdata_r <= {16'h0000, rdat_r};
        SMSL_HOST_STATUS: rdata_r <= {31'h000_0000, busy_r};
        SMSL_HOST_INT_STAT: rdata_r <= {30'h000_0000, ist_r};
        SMSL_HOST_INT_EN: rdata_r <= {30'h000_0000, ien_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_r;
  assign irq = |(ist_r & ien_r);

endmodule : smsl_host

//--- smsl_properties.sv
`timescale 1ns/100ps
module smsl_properties
  import smsl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_host_o,
  input wire logic mdio_host_oe,
  input wire logic mdio_dev_o,
  input wire logic mdio_dev_oe,
  input wire logic mdio_line
);
  // 17 bit times of 50 clocks, a little slack for the sync flops
  localparam int DRIVE_LO = 848;
  localparam int DRIVE_HI = 852;
  logic mdc_q_r;
  logic [7:0] hold_cnt_r;
  logic [11:0] drive_cnt_r;

  // cycles since mdc last moved; saturates so long idles stay legal
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mdc_q_r <= 1'h0;
      hold_cnt_r <= 8'hff;
    end else begin
      mdc_q_r <= mdc;
      if (mdc != mdc_q_r) hold_cnt_r <= 8'h01;
      else if (hold_cnt_r != 8'hff) hold_cnt_r <= hold_cnt_r + 8'h01;
    end
  end

  // cycles for which the device has held the line
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) drive_cnt_r <= 12'h000;
    else drive_cnt_r <= mdio_dev_oe ? drive_cnt_r + 12'h001 : 12'h000;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_dev_start;
    $rose(mdio_dev_oe) && !mdio_dev_o;
  endsequence
  sequence s_dev_edge;
    $changed(mdio_dev_oe) || (mdio_dev_oe && $changed(mdio_dev_o));
  endsequence

  a_host_open_drain: assert property (
    mdio_host_oe |-> !mdio_host_o) else $error("host drives a one");
  a_no_contention: assert property (
    !(mdio_host_oe && mdio_dev_oe)) else $error("both ends drive");
  a_mdc_rate: assert property (
    (mdc != mdc_q_r) |-> hold_cnt_r >= SMSL_MDC_HALF_CYC)
    else $error("mdc too fast");
  a_ta_zero: assert property (
    $rose(mdio_dev_oe) |-> !mdio_dev_o && !mdio_line)
    else $error("turnaround not zero");
  a_host_ta_free: assert property (
    s_dev_start |-> !$past(mdio_host_oe, 20))
    else $error("host held turnaround");
  a_dev_on_rise: assert property (
    s_dev_edge |-> mdc) else $error("device moved in low phase");
  a_drive_len: assert property (
    $fell(mdio_dev_oe) |-> drive_cnt_r >= DRIVE_LO &&
    drive_cnt_r <= DRIVE_HI) else $error("read drive length wrong");
  a_idle_release: assert property (
    (hold_cnt_r > 8'h64 && !mdc) |-> !mdio_host_oe && !mdio_dev_oe)
    else $error("line driven while idle");
  c_read: cover property (s_dev_start);
endmodule : smsl_properties

//--- test_phy_mgmt_serial_slave.sv
`timescale 1ns/100ps
module test_phy_mgmt_serial_slave;
  import smsl_pkg::*;
  typedef struct packed {
    logic [4:0] pa;
    logic [4:0] ra;
    logic [15:0] wv;
    logic [15:0] ex;
  } smsl_row_t;
  logic clk_sys = 1'h0;
  logic rst, wr, rd, irq, hp_we, hp_re, mdc_seen;
  logic [7:0] addr, hp_wdata, hp_rdata, bv;
  logic [31:0] wdata, rdata, v;
  logic [15:0] hp_addr, fv, ba;
  logic [63:0] wire_bits;
  int n_errors = 0;
  int checked = 0;
  int n_rise = 0;
  // write, read back; foreign addresses last so port 1 can be rechecked
  smsl_row_t rows [0:5] = '{
    '{5'h01, 5'h00, 16'h1234, 16'h1234},
    '{5'h04, 5'h1f, 16'habcd, 16'habcd},
    '{5'h02, 5'h0a, 16'h5555, 16'h0000},
    '{5'h03, 5'h01, 16'h7777, 16'h0000},
    '{5'h05, 5'h00, 16'h9999, 16'hffff},
    '{5'h00, 5'h00, 16'h4321, 16'hffff}};

  smsl_if link ();
  smsl_host i_smsl_host (.clk_sys(clk_sys), .rst(rst), .link(link),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq));
  smsl_device i_smsl_device (.clk_sys(clk_sys), .rst(rst), .link(link),
    .hp_addr(hp_addr), .hp_wdata(hp_wdata), .hp_we(hp_we), .hp_re(hp_re),
    .hp_rdata(hp_rdata));
  smsl_properties i_smsl_properties (.clk_sys(clk_sys), .rst(rst),
    .mdc(link.mdc), .mdio_host_o(link.mdio_host_o),
    .mdio_host_oe(link.mdio_host_oe), .mdio_dev_o(link.mdio_dev_o),
    .mdio_dev_oe(link.mdio_dev_oe), .mdio_line(link.mdio_line));

  always #2 clk_sys = ~clk_sys;

  // wire monitor on the falling edge, clear of the edge that moves mdc
  always @(negedge clk_sys) begin
    mdc_seen <= link.mdc;
    if (link.mdc === 1'h1 && mdc_seen === 1'h0) begin
      wire_bits <= {wire_bits[62:0], link.mdio_line};
      n_rise <= n_rise + 1;
    end
  end

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", what, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic hwr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk_sys);
    wr <= 1'h0;
  endtask : hwr

  // read data stand only in the cycle after the strobe
  task automatic hrd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_sys);
    rd <= 1'h0;
    #1 d = rdata;
  endtask : hrd

  task automatic bwr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    hp_addr <= a;
    hp_wdata <= d;
    hp_we <= 1'h1;
    @(posedge clk_sys);
    hp_we <= 1'h0;
  endtask : bwr

  task automatic brd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    hp_addr <= a;
    hp_re <= 1'h1;
    @(posedge clk_sys);
    hp_re <= 1'h0;
    #1 d = hp_rdata;
  endtask : brd

  // one frame: command, poll busy (bounded), fetch read data
  task automatic frame(input logic rnw, input logic [4:0] pa,
    input logic [4:0] ra, input logic [15:0] wv, output logic [15:0] rv);
    logic [31:0] s;
    int n;
    n = 0;
    if (!rnw) hwr(SMSL_HOST_WDATA, {16'h0000, wv});
    hwr(SMSL_HOST_CMD, {21'h0_0000, rnw, pa, ra});
    do begin
      hrd(SMSL_HOST_STATUS, s);
      n++;
    end while (s[0] !== 1'h0 && n < 3000);
    chk("busy", 32'h0000_0000, {31'h0, s[0]});
    hrd(SMSL_HOST_RDATA, s);
    rv = s[15:0];
  endtask : frame

  task automatic finish_test;
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  initial begin
    repeat (90000) @(posedge clk_sys);
    n_errors++;
    finish_test();
  end

  initial begin
    {rst, wr, rd, hp_we, hp_re} = 5'h10;
    {addr, wdata, hp_addr, hp_wdata} = 64'h0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    hrd(SMSL_HOST_STATUS, v);
    chk("status", 32'h0000_0000, v);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    brd(16'h1100, bv);
    chk("store", 32'h0000_0000, {24'h00_0000, bv});
    for (int i = 0; i < 6; i++) begin
      frame(1'h0, rows[i].pa, rows[i].ra, rows[i].wv, fv);
      frame(1'h1, rows[i].pa, rows[i].ra, 16'h0000, fv);
      chk("read", {16'h0, rows[i].ex}, {16'h0, fv});
      if (rows[i].pa >= SMSL_PORT_MIN && rows[i].pa <= SMSL_PORT_MAX) begin
        ba = {rows[i].pa[3:0], 12'h100} + {10'h000, rows[i].ra, 1'h0};
        brd(ba, bv);
        chk("hi", {24'h0, rows[i].ex[15:8]}, {24'h0, bv});
        brd(ba + 16'h0001, bv);
        chk("lo", {24'h0, rows[i].ex[7:0]}, {24'h0, bv});
      end
    end
    brd(16'h1100, bv);
    chk("foreign", 32'h0000_0012, {24'h0, bv});
    // byte port and frames share storage; watch the wire too
    bwr(16'h2104, 8'hc3);
    bwr(16'h2105, 8'h3c);
    n_rise = 0;
    frame(1'h1, 5'h02, 5'h02, 16'h0000, fv);
    chk("shared", 32'h0000_c33c, {16'h0, fv});
    chk("rises", 32'h0000_0040, n_rise);
    chk("pre", 32'hffff_ffff, wire_bits[63:32]);
    chk("wire", {2'h1, 2'h2, 5'h02, 5'h02, 2'h2, 16'hc33c},
        wire_bits[31:0]);
    chk("mdc", 32'h0000_0000, {31'h0, link.mdc});
    // indirect access: address word, then data word, then back
    frame(1'h0, 5'h03, SMSL_REG_EXT_SETUP, 16'h0000, fv);
    frame(1'h0, 5'h03, SMSL_REG_EXT_DATA, 16'h0007, fv);
    frame(1'h0, 5'h03, SMSL_REG_EXT_SETUP, 16'h4000, fv);
    frame(1'h0, 5'h03, SMSL_REG_EXT_DATA, 16'hbeef, fv);
    frame(1'h1, 5'h03, SMSL_REG_EXT_DATA, 16'h0000, fv);
    chk("ext", 32'h0000_beef, {16'h0, fv});
    frame(1'h0, 5'h03, SMSL_REG_EXT_SETUP, 16'h0000, fv);
    frame(1'h1, 5'h03, SMSL_REG_EXT_DATA, 16'h0000, fv);
    chk("ext_addr", 32'h0000_0007, {16'h0, fv});
    // interrupt: only read done enabled, write done stays masked
    hwr(SMSL_HOST_INT_EN, 32'h0000_0001);
    hwr(SMSL_HOST_INT_CLR, 32'h0000_0003);
    hrd(SMSL_HOST_INT_STAT, v);
    chk("ist", 32'h0000_0000, {30'h0, v[1:0]});
    frame(1'h0, 5'h01, SMSL_REG_CROSSOVER, 16'h00f0, fv);
    chk("masked", 32'h0000_0000, {31'h0, irq});
    frame(1'h1, 5'h01, SMSL_REG_CROSSOVER, 16'h0000, fv);
    chk("xover", 32'h0000_00f0, {16'h0, fv});
    chk("irq_on", 32'h0000_0001, {31'h0, irq});
    hwr(SMSL_HOST_INT_CLR, 32'h0000_0001);
    @(posedge clk_sys);
    #1 chk("irq_off", 32'h0000_0000, {31'h0, irq});
    hrd(SMSL_HOST_INT_STAT, v);
    chk("ist2", 32'h0000_0002, {30'h0, v[1:0]});
    // a command while busy is dropped; the first one completes
    hwr(SMSL_HOST_CMD, {21'h0_0000, 1'h1, 5'h01, 5'h00});
    frame(1'h1, 5'h04, 5'h1f, 16'h0000, fv);
    chk("drop", 32'h0000_1234, {16'h0, fv});
    hrd(8'h1c, v);
    chk("unmapped", 32'h0000_0000, v);
    // reset cut into a read while the device drives: both ends restart
    hwr(SMSL_HOST_CMD, {21'h0_0000, 1'h1, 5'h01, 5'h00});
    repeat (2600) @(posedge clk_sys);
    rst <= 1'h1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    hrd(SMSL_HOST_STATUS, v);
    chk("rst_busy", 32'h0000_0000, v);
    chk("rst_irq", 32'h0000_0000, {31'h0, irq});
    chk("rst_oe", 32'h0000_0000, {31'h0, link.mdio_dev_oe});
    frame(1'h1, 5'h01, 5'h00, 16'h0000, fv);
    chk("rst_store", 32'h0000_0000, {16'h0, fv});
    finish_test();
  end
endmodule : test_phy_mgmt_serial_slave
